/* hdl/oag_pkg.sv */
// Constants and types shared by the operand address generator and its register bank.
// Assumes a single core clock domain and an asynchronous active-low core reset.
package oag_pkg;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam int BANKS = 4;
  localparam int REGS_PER_BANK = 8;

  // Byte register codes within a bank.
  localparam logic [2:0] CODE_X = 3'h0;
  localparam logic [2:0] CODE_A = 3'h1;
  localparam logic [2:0] CODE_C = 3'h2;
  localparam logic [2:0] CODE_B = 3'h3;
  localparam logic [2:0] CODE_E = 3'h4;
  localparam logic [2:0] CODE_D = 3'h5;
  localparam logic [2:0] CODE_L = 3'h6;
  localparam logic [2:0] CODE_H = 3'h7;
  // Pair codes.
  localparam logic [1:0] PAIR_AX = 2'h0;
  localparam logic [1:0] PAIR_BC = 2'h1;
  localparam logic [1:0] PAIR_DE = 2'h2;
  localparam logic [1:0] PAIR_HL = 2'h3;

  // Short direct window.
  localparam logic [15:0] SADDR_LO = 16'hFE20;
  localparam logic [15:0] SADDR_HI = 16'hFF1F;
  localparam logic [6:0] SADDR_TOP = 7'h7F;
  localparam logic [7:0] SADDR_WRAP = 8'h20;
  // Special register space.
  localparam logic [15:0] SFR_BASE = 16'hFF00;
  localparam logic [15:0] SFR_GAP_LO = 16'hFFD0;
  localparam logic [15:0] SFR_GAP_HI = 16'hFFDF;
  // Default internal high-speed RAM span for stack accesses.
  localparam logic [15:0] HS_RAM_LO = 16'hFB00;
  localparam logic [15:0] HS_RAM_HI = 16'hFEFF;
  localparam logic [15:0] RESET_ADDR = 16'h0000;

  typedef enum logic [3:0] {
    MODE_IMPLIED, MODE_REG, MODE_PAIR, MODE_DIRECT, MODE_SHORT, MODE_SFR,
    MODE_IND_DE, MODE_IND_HL, MODE_BASED, MODE_IDX_B, MODE_IDX_C, MODE_STACK
  } mode_t;

  typedef enum logic [2:0] {
    unsigned_multiply_op, unsigned_word_divide_op, bcd_add_adjust_op,
    bcd_sub_adjust_op, nibble_rotate_right_op, nibble_rotate_left_op
  } implied_op_t;
endpackage : oag_pkg

/* hdl/regbank_if.sv */
// Port bundle between the address generator and its general register banks.
// Assumes reads are combinational from the bank selected by bank.
`timescale 1ns/1ps
interface regbank_if;
  logic [1:0] bank;
  logic [2:0] byte_code;
  logic [7:0] byte_data;
  logic [1:0] pair_code;
  logic [15:0] pair_data;
  logic [15:0] hl_data;
  logic [15:0] de_data;
  logic [7:0] b_data;
  logic [7:0] c_data;
  logic wr_en;
  logic wr_word;
  logic [2:0] wr_code;
  logic [15:0] wr_data;
  modport gen (output bank, byte_code, pair_code, wr_en, wr_word, wr_code, wr_data,
               input byte_data, pair_data, hl_data, de_data, b_data, c_data);
  modport bank_side (input bank, byte_code, pair_code, wr_en, wr_word, wr_code, wr_data,
                     output byte_data, pair_data, hl_data, de_data, b_data, c_data);
endinterface : regbank_if

/* hdl/reg_banks.sv */
// Four banks of eight byte registers, pairs formed from adjacent bytes (low byte at even code).
// Assumes writes land in the bank currently selected; reads see the value before a same-cycle write.
`timescale 1ns/1ps
module reg_banks (
  input wire logic clk_i,
  input wire logic reset_n_i,
  regbank_if.bank_side rb
);
  localparam int N = oag_pkg::BANKS * oag_pkg::REGS_PER_BANK;
  logic [7:0] mem_q [N];
  logic [7:0] mem_d [N];

  function automatic logic [4:0] idx(input logic [1:0] bank, input logic [2:0] code);
    return {bank, code};
  endfunction : idx

  always_comb begin
    mem_d = mem_q;
    if (rb.wr_en) begin
      if (rb.wr_word) begin
        mem_d[idx(rb.bank, {rb.wr_code[1:0], 1'b0})] = rb.wr_data[7:0];
        mem_d[idx(rb.bank, {rb.wr_code[1:0], 1'b1})] = rb.wr_data[15:8];
      end else begin
        mem_d[idx(rb.bank, rb.wr_code)] = rb.wr_data[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < N; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  // Codes 0..7 are X,A,C,B,E,D,L,H; pair n is {code 2n+1, code 2n}. [R5] [R17]
  assign rb.byte_data = mem_q[idx(rb.bank, rb.byte_code)];
  assign rb.pair_data = {mem_q[idx(rb.bank, {rb.pair_code, 1'b1})], mem_q[idx(rb.bank, {rb.pair_code, 1'b0})]};
  assign rb.hl_data = {mem_q[idx(rb.bank, oag_pkg::CODE_H)], mem_q[idx(rb.bank, oag_pkg::CODE_L)]};
  assign rb.de_data = {mem_q[idx(rb.bank, oag_pkg::CODE_D)], mem_q[idx(rb.bank, oag_pkg::CODE_E)]};
  assign rb.b_data = mem_q[idx(rb.bank, oag_pkg::CODE_B)];
  assign rb.c_data = mem_q[idx(rb.bank, oag_pkg::CODE_C)];
endmodule : reg_banks

/* hdl/operand_address_generator.sv */
// Operand address generator: resolves registers and 16-bit memory operand addresses.
// Assumes the decoder holds its fields valid with req_valid_i for one cycle per operand.
//
// Notes on behaviour
// [R1] Multiply takes A as multiplicand, a named byte register, product goes to AX.
// [R2] Word divide reads dividend from AX and writes quotient back to AX.
// [R3] Decimal adjust and nibble rotates work on A implicitly.
// [R4] Register operands combine both bank flags with the 3-bit register code.
// [R5] Byte codes 0..7 are X,A,C,B,E,D,L,H; pair codes 0..3 are AX,BC,DE,HL.
// [R6] Direct mode uses the 16-bit immediate unchanged as address.
// [R7] Short direct maps an 8-bit immediate into FE20H..FF1FH.
// [R8] Short direct bit 8 is set for 00H..1FH, cleared otherwise; top bits ones.
// [R9] Short window up to FEFFH is RAM, FF00H..FF1FH is special registers.
// [R10] Word short direct operands must be even; the decoder guarantees it.
// [R11] Special register mode reaches FF00H..FFCFH and FFE0H..FFFFH by 8-bit immediate.
// [R12] Word special register operands must be even; the decoder guarantees it.
// [R13] Register indirect uses DE or HL of the selected bank.
// [R14] Based mode adds zero-extended immediate to HL, carry dropped.
// [R15] Based indexed adds zero-extended B or C to HL, carry dropped.
// [R16] Stack accesses use the stack pointer and must stay in high-speed RAM.
// [R17] The two bank flags form a 2-bit index choosing one of four banks.
`timescale 1ns/1ps
module operand_address_generator #(
  parameter logic [15:0] STACK_RAM_LO = oag_pkg::HS_RAM_LO,
  parameter logic [15:0] STACK_RAM_HI = oag_pkg::HS_RAM_HI
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire oag_pkg::mode_t mode_i,
  input wire oag_pkg::implied_op_t implied_op_i,
  input wire logic [2:0] reg_code_i,
  input wire logic [7:0] imm8_i,
  input wire logic [15:0] imm16_i,
  input wire logic bank_select_low_i,
  input wire logic bank_select_high_i,
  input wire logic [15:0] stack_pointer_i,
  input wire logic wr_en_i,
  input wire logic wr_word_i,
  input wire logic [2:0] wr_code_i,
  input wire logic [15:0] wr_data_i,
  output logic done_o,
  output logic is_mem_o,
  output logic [15:0] mem_addr_o,
  output logic to_sfr_o,
  output logic addr_fault_o,
  output logic [2:0] src_code_o,
  output logic [7:0] src_byte_o,
  output logic [15:0] src_pair_o,
  output logic dst_is_pair_o,
  output logic [2:0] dst_code_o
);
  // An empty span would flag every stack access, so such a setting is refused at elaboration.
  if (STACK_RAM_LO > STACK_RAM_HI) begin : g_bad_span
    $error("stack RAM span is empty");
  end

  regbank_if rb ();

  reg_banks u_banks (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .rb(rb)
  );

  // Sum with a zero-extended byte; the carry out of bit 15 is dropped by the cast.
  function automatic logic [15:0] add_ze(input logic [15:0] base, input logic [7:0] off);
    return 16'(base + {8'h00, off});
  endfunction : add_ze

  function automatic logic in_span(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_span

  logic done_d, done_q, mem_d, mem_q, sfr_d, sfr_q, fault_d, fault_q, dpair_d, dpair_q;
  logic [15:0] addr_d, addr_q, pair_d, pair_q;
  logic [7:0] byte_d, byte_q;
  logic [2:0] src_d, src_q, dst_d, dst_q;

  assign rb.bank = {bank_select_high_i, bank_select_low_i}; // [R17] [R4]
  assign rb.wr_en = wr_en_i;
  assign rb.wr_word = wr_word_i;
  assign rb.wr_code = wr_code_i;
  assign rb.wr_data = wr_data_i;

  always_comb begin
    done_d = req_valid_i;
    mem_d = 1'b0;
    sfr_d = 1'b0;
    fault_d = 1'b0;
    addr_d = addr_q;
    src_d = reg_code_i;
    dst_d = reg_code_i;
    dpair_d = 1'b0;
    rb.byte_code = reg_code_i; // [R4]
    rb.pair_code = reg_code_i[1:0];
    case (mode_i)
      oag_pkg::MODE_IMPLIED: begin
        src_d = oag_pkg::CODE_A; // [R3]
        dst_d = oag_pkg::CODE_A;
        rb.byte_code = oag_pkg::CODE_A;
        case (implied_op_i)
          oag_pkg::unsigned_multiply_op: begin
            // Multiplier byte comes from reg_code_i, multiplicand is A. [R1]
            rb.byte_code = reg_code_i;
            dst_d = {1'b0, oag_pkg::PAIR_AX};
            dpair_d = 1'b1;
          end
          oag_pkg::unsigned_word_divide_op: begin
            src_d = {1'b0, oag_pkg::PAIR_AX}; // [R2]
            dst_d = {1'b0, oag_pkg::PAIR_AX};
            dpair_d = 1'b1;
            rb.pair_code = oag_pkg::PAIR_AX;
          end
          default: begin
          end
        endcase
      end
      oag_pkg::MODE_REG: begin
      end
      oag_pkg::MODE_PAIR: begin
        dpair_d = 1'b1;
      end
      oag_pkg::MODE_DIRECT: begin
        mem_d = 1'b1;
        addr_d = imm16_i; // [R6]
      end
      oag_pkg::MODE_SHORT: begin
        mem_d = 1'b1;
        addr_d = {oag_pkg::SADDR_TOP, imm8_i < oag_pkg::SADDR_WRAP, imm8_i}; // [R7] [R8]
        sfr_d = addr_d >= oag_pkg::SFR_BASE; // [R9]
      end
      oag_pkg::MODE_SFR: begin
        mem_d = 1'b1;
        sfr_d = 1'b1;
        addr_d = oag_pkg::SFR_BASE | {8'h00, imm8_i}; // [R11]
        // The unassigned hole between the two special register spans is flagged.
        fault_d = in_span(addr_d, oag_pkg::SFR_GAP_LO, oag_pkg::SFR_GAP_HI); // [R11]
      end
      oag_pkg::MODE_IND_DE: begin
        mem_d = 1'b1;
        addr_d = rb.de_data; // [R13]
      end
      oag_pkg::MODE_IND_HL: begin
        mem_d = 1'b1;
        addr_d = rb.hl_data; // [R13]
      end
      oag_pkg::MODE_BASED: begin
        mem_d = 1'b1;
        addr_d = add_ze(rb.hl_data, imm8_i); // [R14]
      end
      oag_pkg::MODE_IDX_B: begin
        mem_d = 1'b1;
        addr_d = add_ze(rb.hl_data, rb.b_data); // [R15]
      end
      oag_pkg::MODE_IDX_C: begin
        mem_d = 1'b1;
        addr_d = add_ze(rb.hl_data, rb.c_data); // [R15]
      end
      oag_pkg::MODE_STACK: begin
        mem_d = 1'b1;
        addr_d = stack_pointer_i; // [R16]
        fault_d = !in_span(stack_pointer_i, STACK_RAM_LO, STACK_RAM_HI); // [R16]
      end
      default: begin
        fault_d = 1'b1;
      end
    endcase
    byte_d = rb.byte_data;
    pair_d = rb.pair_data;
    if (!req_valid_i) begin
      mem_d = mem_q;
      sfr_d = sfr_q;
      fault_d = fault_q;
      addr_d = addr_q;
      src_d = src_q;
      dst_d = dst_q;
      dpair_d = dpair_q;
      byte_d = byte_q;
      pair_d = pair_q;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_q <= 1'b0;
      mem_q <= 1'b0;
      sfr_q <= 1'b0;
      fault_q <= 1'b0;
      dpair_q <= 1'b0;
      addr_q <= oag_pkg::RESET_ADDR;
      pair_q <= 16'h0000;
      byte_q <= 8'h00;
      src_q <= 3'h0;
      dst_q <= 3'h0;
    end else begin
      done_q <= done_d;
      mem_q <= mem_d;
      sfr_q <= sfr_d;
      fault_q <= fault_d;
      dpair_q <= dpair_d;
      addr_q <= addr_d;
      pair_q <= pair_d;
      byte_q <= byte_d;
      src_q <= src_d;
      dst_q <= dst_d;
    end
  end

  assign done_o = done_q;
  assign is_mem_o = mem_q;
  assign mem_addr_o = addr_q;
  assign to_sfr_o = sfr_q;
  assign addr_fault_o = fault_q;
  assign src_code_o = src_q;
  assign src_byte_o = byte_q;
  assign src_pair_o = pair_q;
  assign dst_is_pair_o = dpair_q;
  assign dst_code_o = dst_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_direct_pass: assert property (req_valid_i && mode_i == oag_pkg::MODE_DIRECT |=> // [R6]
    mem_addr_o == $past(imm16_i) && is_mem_o) else $error("direct address altered");
  a_short_bit8: assert property (req_valid_i && mode_i == oag_pkg::MODE_SHORT |=> // [R8]
    mem_addr_o[15:9] == 7'h7F && mem_addr_o[8] == ($past(imm8_i) < 8'h20)) else $error("short bit 8 wrong");
  a_short_window: assert property (done_o && $past(mode_i) == oag_pkg::MODE_SHORT |-> // [R7]
    in_span(mem_addr_o, oag_pkg::SADDR_LO, oag_pkg::SADDR_HI)) else $error("short address outside window");
  a_short_sfr_split: assert property (done_o && $past(mode_i) == oag_pkg::MODE_SHORT |-> // [R9]
    to_sfr_o == (mem_addr_o >= oag_pkg::SFR_BASE)) else $error("short region wrong");
  a_sfr_base: assert property (req_valid_i && mode_i == oag_pkg::MODE_SFR |=> // [R11]
    mem_addr_o[15:8] == 8'hFF && to_sfr_o) else $error("sfr address wrong");
  a_based_sum: assert property (req_valid_i && mode_i == oag_pkg::MODE_BASED |=> // [R14]
    mem_addr_o == 16'($past(rb.hl_data) + {8'h00, $past(imm8_i)})) else $error("based sum wrong");
  a_index_sum: assert property (req_valid_i && mode_i == oag_pkg::MODE_IDX_C |=> // [R15]
    mem_addr_o == 16'($past(rb.hl_data) + {8'h00, $past(rb.c_data)})) else $error("indexed sum wrong");
  a_indirect_de: assert property (req_valid_i && mode_i == oag_pkg::MODE_IND_DE |=> // [R13]
    mem_addr_o == $past(rb.de_data)) else $error("indirect address wrong");
  a_mul_implied: assert property (req_valid_i && mode_i == oag_pkg::MODE_IMPLIED && // [R1]
    implied_op_i == oag_pkg::unsigned_multiply_op |=> dst_is_pair_o && dst_code_o == 3'h0 && src_code_o == 3'h1)
    else $error("multiply operands wrong");
  a_div_implied: assert property (req_valid_i && mode_i == oag_pkg::MODE_IMPLIED && // [R2]
    implied_op_i == oag_pkg::unsigned_word_divide_op |=> dst_is_pair_o && dst_code_o == 3'h0 && src_code_o == 3'h0)
    else $error("divide operands wrong");
  a_stack_fault: assert property (req_valid_i && mode_i == oag_pkg::MODE_STACK |=> // [R16]
    mem_addr_o == $past(stack_pointer_i) &&
    addr_fault_o == !in_span(mem_addr_o, STACK_RAM_LO, STACK_RAM_HI)) else $error("stack check wrong");
  a_done_hold: assert property (!req_valid_i |=> !done_o && $stable(mem_addr_o)) else $error("idle output moved");

  c_short_sfr: cover property (done_o && to_sfr_o && $past(mode_i) == oag_pkg::MODE_SHORT);
  c_based_wrap: cover property (req_valid_i && mode_i == oag_pkg::MODE_BASED && rb.hl_data == 16'hFFFF);
  c_stack_fault: cover property (done_o && addr_fault_o);
  c_bank3: cover property (req_valid_i && bank_select_high_i && bank_select_low_i && mode_i == oag_pkg::MODE_IND_HL);
endmodule : operand_address_generator

/* sim/datapath_model.sv */
// Datapath stand-in: mirrors every register write into shadow banks for the bench.
// Assumes a write lands in the bank selected at the same edge, as the block under test does.
`timescale 1ns/1ps
module datapath_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire logic wr_word_i,
  input wire logic [2:0] wr_code_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [1:0] bank_i,
  output logic [255:0] shadow_o
);
  logic [4:0] base;
  assign base = {bank_i, 3'h0};
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shadow_o <= '0;
    end else if (wr_en_i && wr_word_i) begin
      shadow_o[{base + 5'({wr_code_i[1:0], 1'b0}), 3'h0} +: 16] <= wr_data_i;
    end else if (wr_en_i) begin
      shadow_o[{base + 5'(wr_code_i), 3'h0} +: 8] <= wr_data_i[7:0];
    end
  end
endmodule : datapath_model

/* sim/operand_address_generator_tb.sv */
// Self-checking bench for the operand address generator, random and corner requests.
// Assumes the block's latency of one cycle and a shadow of the banks kept by the datapath model.
`timescale 1ns/1ps
module operand_address_generator_tb;
  logic clk, reset_n, req_valid, bank_lo, bank_hi, wr_en, wr_word;
  oag_pkg::mode_t mode;
  oag_pkg::implied_op_t implied_op;
  logic [2:0] reg_code, wr_code, src_code, dst_code;
  logic [7:0] imm8, src_byte;
  logic [15:0] imm16, sp, wr_data, mem_addr, src_pair;
  logic done, is_mem, to_sfr, fault, dst_is_pair;
  logic [255:0] shadow;
  int checked, miscompares, cycles, seed;
  logic [31:0] v;

  operand_address_generator u_dut (.clk_i(clk), .reset_n_i(reset_n), .req_valid_i(req_valid), .mode_i(mode),
    .implied_op_i(implied_op), .reg_code_i(reg_code), .imm8_i(imm8), .imm16_i(imm16), .bank_select_low_i(bank_lo),
    .bank_select_high_i(bank_hi), .stack_pointer_i(sp), .wr_en_i(wr_en), .wr_word_i(wr_word), .wr_code_i(wr_code),
    .wr_data_i(wr_data), .done_o(done), .is_mem_o(is_mem), .mem_addr_o(mem_addr), .to_sfr_o(to_sfr),
    .addr_fault_o(fault), .src_code_o(src_code), .src_byte_o(src_byte), .src_pair_o(src_pair),
    .dst_is_pair_o(dst_is_pair), .dst_code_o(dst_code));
  datapath_model u_model (.clk_i(clk), .reset_n_i(reset_n), .wr_en_i(wr_en), .wr_word_i(wr_word),
    .wr_code_i(wr_code), .wr_data_i(wr_data), .bank_i({bank_hi, bank_lo}), .shadow_o(shadow));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic conclude();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic check_val(logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check_val

  task automatic check_flag(logic exp, logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check_flag

  function automatic logic [7:0] byte_at(logic [1:0] bk, logic [2:0] c);
    return shadow[{bk, c, 3'h0} +: 8];
  endfunction : byte_at

  function automatic logic [15:0] pair_at(logic [1:0] bk, logic [1:0] p);
    return {byte_at(bk, {p, 1'b1}), byte_at(bk, {p, 1'b0})};
  endfunction : pair_at

  function automatic logic [15:0] exp_addr(oag_pkg::mode_t m, logic [1:0] bk);
    case (m)
      oag_pkg::MODE_DIRECT: return imm16;
      oag_pkg::MODE_SHORT: return {7'h7F, imm8 < 8'h20, imm8};
      oag_pkg::MODE_SFR: return {8'hFF, imm8};
      oag_pkg::MODE_IND_DE: return pair_at(bk, 2'h2);
      oag_pkg::MODE_IND_HL: return pair_at(bk, 2'h3);
      oag_pkg::MODE_BASED: return pair_at(bk, 2'h3) + {8'h00, imm8};
      oag_pkg::MODE_IDX_B: return pair_at(bk, 2'h3) + {8'h00, byte_at(bk, 3'h3)};
      oag_pkg::MODE_IDX_C: return pair_at(bk, 2'h3) + {8'h00, byte_at(bk, 3'h2)};
      default: return sp;
    endcase
  endfunction : exp_addr

  function automatic logic exp_fault(oag_pkg::mode_t m);
    if (m == oag_pkg::MODE_SFR) return imm8 >= 8'hD0 && imm8 <= 8'hDF;
    if (m == oag_pkg::MODE_STACK) return sp < oag_pkg::HS_RAM_LO || sp > oag_pkg::HS_RAM_HI;
    return m > oag_pkg::MODE_STACK;
  endfunction : exp_fault

  // The strobe is left up for a following write; the next request lowers it, so no edge sees a glitch.
  task automatic wr(logic word, logic [2:0] code, logic [15:0] data);
    req_valid = 1'b0;
    wr_en = 1'b1;
    wr_word = word;
    wr_code = code;
    wr_data = data;
    @(negedge clk);
  endtask : wr

  task automatic send(oag_pkg::mode_t m, logic [2:0] op, logic [2:0] code, logic [7:0] i8);
    logic [1:0] bk;
    logic [15:0] ea;
    logic flt;
    wr_en = 1'b0;
    mode = m;
    implied_op = oag_pkg::implied_op_t'(op);
    reg_code = code;
    imm8 = i8;
    req_valid = 1'b1;
    bk = {bank_hi, bank_lo};
    ea = exp_addr(m, bk);
    flt = exp_fault(m);
    @(negedge clk);
    check_flag(1'b1, done);
    check_flag(flt, fault);
    if (m == oag_pkg::MODE_IMPLIED && op == 3'h0) begin
      check_val(16'h0001, 16'(src_code));
      check_val(16'(byte_at(bk, code)), 16'(src_byte));
      check_flag(1'b1, dst_is_pair);
    end else if (m == oag_pkg::MODE_IMPLIED && op == 3'h1) begin
      check_val(pair_at(bk, 2'h0), src_pair);
      check_val(16'h0000, 16'(dst_code));
    end else if (m == oag_pkg::MODE_IMPLIED) begin
      check_val(16'h0001, 16'(dst_code));
      check_val(16'(byte_at(bk, 3'h1)), 16'(src_byte));
    end else if (m == oag_pkg::MODE_REG) begin
      check_val(16'(byte_at(bk, code)), 16'(src_byte));
    end else if (m == oag_pkg::MODE_PAIR) begin
      check_val(pair_at(bk, code[1:0]), src_pair);
    end else if (m <= oag_pkg::MODE_STACK) begin
      check_flag(1'b1, is_mem);
      check_val(ea, mem_addr);
    end
    if (m == oag_pkg::MODE_SHORT || m == oag_pkg::MODE_SFR) begin
      check_flag(ea >= 16'hFF00, to_sfr);
    end
  endtask : send

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    {req_valid, bank_lo, bank_hi, wr_en, wr_word, reg_code, wr_code, imm8, imm16, sp, wr_data} = '0;
    mode = oag_pkg::MODE_IMPLIED;
    implied_op = oag_pkg::unsigned_multiply_op;
    {checked, miscompares, cycles} = '0;
    seed = 78;
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    check_flag(1'b0, done);
    check_val(16'h0000, mem_addr);
    {bank_hi, bank_lo} = 2'h2;
    wr(1'b1, 3'h3, 16'hFFFF);
    wr(1'b1, 3'h1, 16'h0580);
    send(oag_pkg::MODE_BASED, 3'h0, 3'h0, 8'h01);
    send(oag_pkg::MODE_IDX_B, 3'h0, 3'h0, 8'h00);
    send(oag_pkg::MODE_IDX_C, 3'h0, 3'h0, 8'h00);
    foreach (v[i]) begin
      sp = 16'hFAFF + 16'(i * 16'h0080);
      send(oag_pkg::MODE_SHORT, 3'h0, 3'h0, 8'h1F + 8'(i));
      send(oag_pkg::MODE_SFR, 3'h0, 3'h0, 8'hC8 + 8'(i));
      send(oag_pkg::MODE_STACK, 3'h0, 3'h0, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      send(oag_pkg::MODE_IMPLIED, 3'(i), 3'(i + 2), 8'h00);
    end
    send(oag_pkg::mode_t'(4'hC), 3'h0, 3'h0, 8'h00);
    for (int i = 0; i < 300; i++) begin
      v = $random(seed);
      {bank_hi, bank_lo} = v[5:4];
      sp = v[31:16];
      imm16 = v[31:16] ^ v[15:0];
      if (v[6]) begin
        wr(v[7], v[10:8], v[31:16]);
      end
      // Byte forms take any immediate; word forms would arrive even from the decoder.
      send(oag_pkg::mode_t'(v[15:12] % 4'hC), v[2:0] % 3'h6, v[10:8], v[23:16]);
    end
    conclude();
  end
endmodule : operand_address_generator_tb
